/* include/sdiag_pkg.sv */
/*
 Constants for the serial diagnostic status block: status, detail and
 request bit positions, reset values and timing counts.
 Assumes a 100 MHz system clock.
*/
package sdiag_pkg;
	localparam int          CLK_HZ         = 100_000_000;
	localparam int          MAX_CHAIN      = 31;
	localparam int          WARN_TIME_MIN  = 30;
	localparam longint      WARN_CYCLES    = longint'(WARN_TIME_MIN) * 60 * CLK_HZ;
	// Response status byte bits
	localparam int          RSP_OUT_EN     = 0;
	localparam int          RSP_ACT_ID     = 1;
	localparam int          RSP_FB_OPEN    = 3;
	localparam int          RSP_INPUTS     = 4;
	localparam int          RSP_HYST       = 5;
	localparam int          RSP_WARN       = 6;
	localparam int          RSP_ERR        = 7;
	// Fault detail byte bits
	localparam int          DET_OUT1       = 0;
	localparam int          DET_OUT2       = 1;
	localparam int          DET_CROSS      = 2;
	localparam int          DET_TEMP       = 3;
	localparam int          DET_ACTUATOR   = 4;
	localparam int          DET_INTERNAL   = 5;
	localparam int          DET_COMM       = 6;
	// Request command byte bits
	localparam int          REQ_ERR_ACK    = 7;
	localparam logic [7:0]  BYTE_RESET     = 8'h00;
endpackage

/* rtl/sdiag_status.sv */
/*
 Serial diagnostic status and fault management of one chained safety sensor.
 Builds the response status byte and fault detail byte, takes the request
 command byte, latches errors, times warnings and gates the safety outputs.
 Assumes fault causes and sensor conditions arrive synchronous to clock.
*/
// Behaviour
// - Chain holds at most 31 sensors, each with its own byte slots.
// - Response and detail bytes are driven continuously, no poll needed.
// - On gateway communication loss, safety outputs keep their state; link loss counts as a warning, so after 30 minutes they go off.
// - Status bit 0 means outputs enabled; bit 1 actuator present and identified.
// - Bit 3 feedback open or reset not pressed; bit 4 both inputs energised.
// - Bit 5 hysteresis margin; bit 6 warning delayed off, also set with any error; bit 7 error.
// - Every status, warning and error bit is active high.
// - Internal safety error switches safety outputs off promptly.
// - Latched error clears once cause gone and request bit 7 falls or guard opens.
// - Output-related errors stay latched until the next output enabling.
// - Non-critical fault gives warning, outputs stay enabled.
// - Warning clears itself as soon as its cause disappears.
// - Warning lasting 30 minutes also switches the safety outputs off.
// - Detail byte shows faults whenever a warning or error is flagged.
// - Detail bits 0 to 3: output one, output two, cross-wiring, overtemperature.
// - Warning detail bit 6 flags gateway communication failure.
// - Error detail bit 4 wrong actuator, bit 5 internal failure.
`timescale 1ns/1ps
module sdiag_status #(
	parameter int     CHAIN_POS   = 0,
	parameter longint WARN_LIMIT  = sdiag_pkg::WARN_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Sensor conditions
	input  wire logic        actuator_identified,
	input  wire logic        actuator_in_hysteresis,
	input  wire logic        feedback_closed,
	input  wire logic        safety_input_one,
	input  wire logic        safety_input_two,
	input  wire logic        guard_open,
	// Fault causes, warning class
	input  wire logic        warn_out1,
	input  wire logic        warn_out2,
	input  wire logic        warn_cross,
	input  wire logic        warn_temp,
	input  wire logic        warn_internal,
	// Fault causes, error class
	input  wire logic        err_out1,
	input  wire logic        err_out2,
	input  wire logic        err_cross,
	input  wire logic        err_temp,
	input  wire logic        err_actuator,
	input  wire logic        err_internal,
	// Link to gateway
	input  wire logic        comm_ok,
	input  wire logic        request_valid,
	input  wire logic [7:0]  request_command_byte,
	// Results
	output logic [7:0]       response_status_byte,
	output logic [7:0]       fault_detail_byte,
	output logic             safety_output_one,
	output logic             safety_output_two
);
	// Refused at elaboration: positions past the chain end, empty timer
	if (CHAIN_POS < 0 || CHAIN_POS >= sdiag_pkg::MAX_CHAIN)
	begin : g_bad_pos
		$error("Chain position out of range");
	end
	if (WARN_LIMIT < 1)
	begin : g_bad_limit
		$error("Warning limit must be positive");
	end

	function automatic logic any_bit(input logic [7:0] v);
		any_bit = |v;
	endfunction

	// Output faults cannot be seen repaired until the outputs enable again
	function automatic logic is_output_fault(input int idx);
		is_output_fault = (idx <= sdiag_pkg::DET_CROSS);
	endfunction

	// Whether one latched error bit may drop; a live cause always keeps it
	function automatic logic may_clear(
		input int   idx,
		input logic cause,
		input logic rel_edge,
		input logic ack,
		input logic guard
	);
		if (cause)
			may_clear = 1'b0;
		else if (is_output_fault(idx))
			may_clear = rel_edge;
		else
			may_clear = ack || guard;
	endfunction

	// Conditions under which the outputs may enable
	function automatic logic enable_ready(
		input logic act_id,
		input logic fb_closed,
		input logic in1,
		input logic in2
	);
		enable_ready = act_id && fb_closed && in1 && in2;
	endfunction

	// Warning vector in detail byte order
	function automatic logic [7:0] warn_pack(
		input logic out1,
		input logic out2,
		input logic crossed,
		input logic temp,
		input logic internal,
		input logic link_lost
	);
		warn_pack                          = sdiag_pkg::BYTE_RESET;
		warn_pack[sdiag_pkg::DET_OUT1]     = out1;
		warn_pack[sdiag_pkg::DET_OUT2]     = out2;
		warn_pack[sdiag_pkg::DET_CROSS]    = crossed;
		warn_pack[sdiag_pkg::DET_TEMP]     = temp;
		warn_pack[sdiag_pkg::DET_INTERNAL] = internal;
		warn_pack[sdiag_pkg::DET_COMM]     = link_lost;
	endfunction

	// Error vector in detail byte order
	function automatic logic [7:0] err_pack(
		input logic out1,
		input logic out2,
		input logic crossed,
		input logic temp,
		input logic actuator,
		input logic internal
	);
		err_pack                          = sdiag_pkg::BYTE_RESET;
		err_pack[sdiag_pkg::DET_OUT1]     = out1;
		err_pack[sdiag_pkg::DET_OUT2]     = out2;
		err_pack[sdiag_pkg::DET_CROSS]    = crossed;
		err_pack[sdiag_pkg::DET_TEMP]     = temp;
		err_pack[sdiag_pkg::DET_ACTUATOR] = actuator;
		err_pack[sdiag_pkg::DET_INTERNAL] = internal;
	endfunction

	// Response byte layout; bit 2 carries no meaning and stays low
	function automatic logic [7:0] status_pack(
		input logic out_en,
		input logic act_id,
		input logic fb_closed,
		input logic inputs_live,
		input logic hyst,
		input logic warn_any,
		input logic err_any
	);
		status_pack                         = sdiag_pkg::BYTE_RESET;
		status_pack[sdiag_pkg::RSP_OUT_EN]  = out_en;
		status_pack[sdiag_pkg::RSP_ACT_ID]  = act_id;
		status_pack[sdiag_pkg::RSP_FB_OPEN] = !fb_closed;
		status_pack[sdiag_pkg::RSP_INPUTS]  = inputs_live;
		status_pack[sdiag_pkg::RSP_HYST]    = hyst;
		status_pack[sdiag_pkg::RSP_WARN]    = warn_any || err_any;
		status_pack[sdiag_pkg::RSP_ERR]     = err_any;
	endfunction

	// Error details take priority over warning details
	function automatic logic [7:0] detail_pick(
		input logic [7:0] errs,
		input logic [7:0] warns
	);
		if (any_bit(errs))
			detail_pick = errs;
		else
			detail_pick = warns;
	endfunction

	logic [7:0]  warn_vec;
	logic [7:0]  err_cause;
	logic [7:0]  err_q;
	logic [7:0]  err_d;
	logic        ack_q;
	logic        outs_q;
	logic        outs_d;
	logic        warn_exp_q;
	logic [63:0] warn_cnt_q;
	logic        comm_lost;
	logic        enable_req;
	logic        enable_q;
	logic        release_edge;
	logic        outs_block;
	logic        warn_any;
	logic        err_any;

	assign comm_lost = !comm_ok;

	assign warn_vec = warn_pack(
		warn_out1,
		warn_out2,
		warn_cross,
		warn_temp,
		warn_internal,
		comm_lost
	);

	assign err_cause = err_pack(
		err_out1,
		err_out2,
		err_cross,
		err_temp,
		err_actuator,
		err_internal
	);

	// Acknowledge edge: request bit 7 falling, only from fresh requests
	logic ack_fall;
	assign ack_fall = request_valid && ack_q && !request_command_byte[sdiag_pkg::REQ_ERR_ACK];

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ack_q <= 1'b0;
		else if (request_valid)
			ack_q <= request_command_byte[sdiag_pkg::REQ_ERR_ACK];
	end

	// Conditions to enable outputs; errors and expired warnings block it
	assign enable_req = enable_ready(
		actuator_identified,
		feedback_closed,
		safety_input_one,
		safety_input_two
	);

	// Release: enabling conditions newly met; clears output faults
	assign release_edge = enable_req && !enable_q;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			enable_q <= 1'b0;
		else
			enable_q <= enable_req;
	end

	// Error latch; a new cause wins over any clear in the same cycle
	always_comb
	begin
		err_d = err_q;
		for (int i = 0; i < 8; i++)
		begin
			if (may_clear(i, err_cause[i], release_edge, ack_fall, guard_open))
				err_d[i] = 1'b0;
		end
		err_d = err_d | err_cause;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			err_q <= sdiag_pkg::BYTE_RESET;
		else
			err_q <= err_d;
	end

	// Warning timer, restarted whenever the warning vanishes; saturates
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			warn_cnt_q <= '0;
		else if (!any_bit(warn_vec))
			warn_cnt_q <= '0;
		else if (warn_cnt_q < 64'(WARN_LIMIT - 1))
			warn_cnt_q <= warn_cnt_q + 64'd1;
	end

	// Expiry flag, held while the same warning episode lasts
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			warn_exp_q <= 1'b0;
		else if (!any_bit(warn_vec))
			warn_exp_q <= 1'b0;
		else if (warn_cnt_q >= 64'(WARN_LIMIT - 1))
			warn_exp_q <= 1'b1;
	end

	// Latched or live errors and an expired warning force the outputs off
	assign outs_block = any_bit(err_q) || any_bit(err_cause) || warn_exp_q;

	// Output gate; errors and expired warnings force off, else on link loss the outputs hold
	always_comb
	begin
		if (outs_block)
			outs_d = 1'b0;
		else if (comm_lost)
			outs_d = outs_q;
		else
			outs_d = enable_req;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			outs_q <= 1'b0;
		else
			outs_q <= outs_d;
	end

	// Both channels fed from one gate; two flops mirror the two pins
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			safety_output_one <= 1'b0;
		else
			safety_output_one <= outs_d;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			safety_output_two <= 1'b0;
		else
			safety_output_two <= outs_d;
	end

	assign warn_any = any_bit(warn_vec);
	assign err_any  = any_bit(err_d);

	// Response byte rebuilt every cycle, no poll needed
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			response_status_byte <= sdiag_pkg::BYTE_RESET;
		else
			response_status_byte <= status_pack(
				outs_d,
				actuator_identified,
				feedback_closed,
				safety_input_one && safety_input_two,
				actuator_in_hysteresis,
				warn_any,
				err_any
			);
	end

	// Detail byte follows the latched errors, else the live warnings
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			fault_detail_byte <= sdiag_pkg::BYTE_RESET;
		else
			fault_detail_byte <= detail_pick(err_d, warn_vec);
	end
endmodule

/* verif/sdiag_gw_model.sv */
/*
 Gateway side model: link health and request bytes.
 Assumes the bench calls its tasks.
*/
`timescale 1ns/1ps
module sdiag_gw_model (
	// Clock
	input  wire logic       clock,
	// Link to sensor
	output logic            comm_ok,
	output logic            request_valid,
	output logic [7:0]      request_command_byte
);
	initial
	begin
		comm_ok = 1'b1;
		request_valid = 1'b0;
		request_command_byte = 8'h00;
	end
	// One byte a request; data inverted once released
	task send(input logic [7:0] b);
		@(posedge clock);
		request_valid <= 1'b1;
		request_command_byte <= b;
		@(posedge clock);
		request_valid <= 1'b0;
		request_command_byte <= ~b;
	endtask
	task link(input logic up);
		@(posedge clock);
		comm_ok <= up;
	endtask
endmodule

/* verif/sdiag_status_assertions.sv */
/*
 Port checker for sdiag_status.
 Assumes bind by name to the top module.
*/
`timescale 1ns/1ps
module sdiag_status_chk (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// Inputs watched
	input wire logic       actuator_identified,
	input wire logic       safety_input_one,
	input wire logic       safety_input_two,
	input wire logic       err_internal,
	input wire logic       comm_ok,
	// Results
	input wire logic [7:0] response_status_byte,
	input wire logic [7:0] fault_detail_byte,
	input wire logic       safety_output_one,
	input wire logic       safety_output_two
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	b2_zero_a: assert property (response_status_byte[2] == 1'b0) else $error("bit 2 set");
	act_bit_a: assert property (!$past(rst) |-> response_status_byte[1] == $past(actuator_identified))
		else $error("bit 1 wrong");
	in_bit_a: assert property (!$past(rst) |-> response_status_byte[4] == $past(safety_input_one & safety_input_two))
		else $error("bit 4 wrong");
	err_off_a: assert property (err_internal |=> response_status_byte[7] && !safety_output_one)
		else $error("error kept outputs on");
	err_bit_a: assert property (response_status_byte[7] |-> !safety_output_one) else $error("error bit with outputs");
	out_pair_a: assert property (safety_output_one == safety_output_two) else $error("outputs differ");
	en_bit_a: assert property (response_status_byte[0] == safety_output_one) else $error("bit 0 wrong");
	comm_hold_a: assert property (!comm_ok && !err_internal |=> $stable(safety_output_one))
		else $error("outputs moved on link loss");
	det_shown_a: assert property (response_status_byte[6] |-> fault_detail_byte != 8'h00)
		else $error("detail empty");
endmodule
bind sdiag_status sdiag_status_chk u_chk (.*);

/* verif/sdiag_status_tb_top.sv */
/*
 Bench for sdiag_status with queued expectations.
 Assumes the gateway model and checker files.
*/
`timescale 1ns/1ps
module sdiag_status_tb_top;
	logic             clock = 1'b0;
	logic             rst = 1'b1;
	logic [16:0]      s = '0;
	logic             hy;
	logic             comm_ok, request_valid, safety_output_one, safety_output_two;
	logic [7:0]       request_command_byte, response_status_byte, fault_detail_byte;
	int               n_fail = 0, n_tests = 0, cyc = 0, i;
	logic [31:0]      q[$];
	initial forever #5 clock = ~clock;
	sdiag_gw_model gw (.*);
	sdiag_status #(.WARN_LIMIT(20)) DUT (.*, .actuator_identified(s[0]), .actuator_in_hysteresis(s[1]),
		.feedback_closed(s[2]), .safety_input_one(s[3]), .safety_input_two(s[4]), .guard_open(s[5]),
		.warn_out1(s[6]), .warn_out2(s[7]), .warn_cross(s[8]), .warn_temp(s[9]), .warn_internal(s[10]),
		.err_out1(s[11]), .err_out2(s[12]), .err_cross(s[13]), .err_temp(s[14]), .err_actuator(s[15]),
		.err_internal(s[16]));
	task end_sim;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input logic [15:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Hold inputs long enough for any one-cycle latency
	task st(input logic [16:0] v, input logic [7:0] r, d, input int n = 3);
		@(posedge clock);
		s <= v;
		repeat (n) @(posedge clock);
		q.push_back({cyc[15:0] + 16'd1, r, d});
	endtask
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			end_sim;
		end
	end
	always @(negedge clock)
		if (q.size() > 0 && q[0][31:16] == cyc[15:0])
		begin
			cmp(q[0][15:0], {response_status_byte, fault_detail_byte});
			void'(q.pop_front());
		end
	initial
	begin
		void'($urandom(71));
		hy = 1'($urandom % 2);
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		st(17'h1C, 8'h10, 8'h00);
		st(17'h19, 8'h1A, 8'h00);
		st(17'h1D | 17'(hy) << 1, 8'h13 | 8'(hy) << 5, 8'h00);
		st(17'h1F, 8'h33, 8'h00);
		$display("status done");
		for (i = 0; i < 5; i++)
		begin
			st(17'h1D | 17'h40 << i, 8'h53, i < 4 ? 8'h01 << i : 8'h20);
			st(17'h1D, 8'h13, 8'h00);
		end
		gw.link(1'b0);
		st(17'h1D, 8'h53, 8'h40);
		gw.link(1'b1);
		st(17'h1D, 8'h13, 8'h00);
		$display("warning done");
		st(17'h1001D, 8'hD2, 8'h20);
		st(17'h1D, 8'hD2, 8'h20);
		gw.send(8'h80);
		gw.send(8'h00);
		st(17'h1D, 8'h13, 8'h00);
		st(17'h801D, 8'hD2, 8'h10);
		st(17'h3C, 8'h10, 8'h00);
		st(17'h1D, 8'h13, 8'h00);
		st(17'h81D, 8'hD2, 8'h01);
		st(17'h1D, 8'hD2, 8'h01);
		st(17'h3C, 8'hD0, 8'h01);
		st(17'h1D, 8'h13, 8'h00);
		$display("error done");
		st(17'h21D, 8'h52, 8'h08, 25);
		$display("timer done");
		repeat (5) @(posedge clock);
		end_sim;
	end
endmodule
